// ---- tpc_pkg.sv ----
// Package for the timer/PWM counter base: register map, fields, reset values
`default_nettype none
package tpc_pkg;
   // ==========================================
   // Register word addresses (byte address = 4 * index)
   localparam logic [3:0] TPC_IDX_SC    = 4'h0;
   localparam logic [3:0] TPC_IDX_CNTH  = 4'h1;
   localparam logic [3:0] TPC_IDX_CNTL  = 4'h2;
   localparam logic [3:0] TPC_IDX_MODH  = 4'h3;
   localparam logic [3:0] TPC_IDX_MODL  = 4'h4;
   localparam int         TPC_ADR_LSB   = 2;
   localparam int         TPC_ADR_W     = 4;

   // ==========================================
   // Status/control fields
   localparam int TPC_SC_OVF  = 7;
   localparam int TPC_SC_OIE  = 6;
   localparam int TPC_SC_CAS  = 5;
   localparam int TPC_SC_CSH  = 4;
   localparam int TPC_SC_CSL  = 3;
   localparam int TPC_SC_PSH  = 2;
   localparam int TPC_SC_PSL  = 0;

   localparam logic [1:0]  TPC_CLK_NONE = 2'h0;
   localparam logic [1:0]  TPC_CLK_BUS  = 2'h1;
   localparam logic [1:0]  TPC_CLK_FIX  = 2'h2;
   localparam logic [1:0]  TPC_CLK_EXT  = 2'h3;

   localparam logic [15:0] TPC_CNT_RST  = 16'h0000;
   localparam logic [15:0] TPC_MOD_RST  = 16'h0000;
   localparam logic [15:0] TPC_MOD_ONES = 16'hffff;
   localparam logic [15:0] TPC_CNT_ONE  = 16'h0001;
   localparam logic [6:0]  TPC_PS_ONE   = 7'h01;

   // Control fields as a carrier for the counter logic
   typedef struct packed {
      logic       irq_en;
      logic       center;
      logic [1:0] clk_src;
      logic [2:0] prescale;
   } tpc_ctrl_t;
endpackage
`default_nettype wire

// ---- tpc_counter_base.sv ----
// Timer/PWM counter base: clock select, prescaler, 16-bit counter, Wishbone registers
//
// Register access over Wishbone and the register addresses were chosen for this implementation.
`default_nettype none
// Operation
// - Up mode: overflow flag sets when counter steps to zero after modulo.
// - Center mode: flag sets at modulo when the counter steps down.
// - Flag in bit 7 clears by read while set, then write zero.
// - An overflow between read and clearing write cancels the clear.
// - Writing one to the flag does nothing; reset clears it.
// - Bit 6 enables interrupt request while the flag is one.
// - Bit 5 selects center-aligned up/down counting; reset clears it.
// - Bits 4:3 select none, bus, fixed system or external clock.
// - External and fixed system clocks pass a bus-clock synchronizer.
// - Bits 2:0 divide the selected clock by two to that power.
// - Prescaler follows selection and synchronization for any source.
// - Counter bytes ignore write data; reading one freezes both until the next counter byte read.
// - Coherency latch re-arms on reset, counter write or control write.
// - Reset clears the counter to zero.
// - Debug mode stops the counter and holds the coherency latch.
// - At modulo: restart from zero, or count down in center mode.
// - Writing one modulo byte blocks flag setting until a second modulo byte write.
// - Reset loads modulo zero, making the counter free-running.
// - A write to either counter byte with byte lane 0 selected clears the counter.
// - Modulo of all ones behaves as zero, free-running.
module tpc_counter_base
   import tpc_pkg::*;
#(
   parameter int PS_W = 7
) (
   // Clock and reset
   input  wire  logic        sys_clk_i,
   input  wire  logic        reset_n_i,
   // Wishbone slave
   input  wire  logic        wb_cyc_i,
   input  wire  logic        wb_stb_i,
   input  wire  logic        wb_we_i,
   input  wire  logic [31:0] wb_adr_i,
   input  wire  logic [31:0] wb_dat_i,
   input  wire  logic [3:0]  wb_sel_i,
   output logic [31:0]       wb_dat_o,
   output logic              wb_ack_o,
   // Clock sources and debug
   input  wire  logic        fixed_system_clock_i,
   input  wire  logic        external_timer_clock_in_i,
   input  wire  logic        debug_mode_i,
   // Time base outputs
   output logic [15:0]       count_o,
   output logic              center_aligned_select_o,
   output logic              overflow_irq_o
);

   // ==========================================
   // Registers
   logic              overflow_flag_reg;
   tpc_ctrl_t         ctrl_reg;
   logic [15:0]       count_reg;
   logic              count_down_reg;
   logic [15:0]       modulo_reg;
   logic [7:0]        mod_hold_reg;
   logic              mod_pend_reg;
   logic              clr_armed_reg;
   logic              latched_reg;
   logic [15:0]       latch_val_reg;
   logic [PS_W-1:0]   ps_count_reg;
   logic [2:0]        fix_sync_reg;
   logic [2:0]        ext_sync_reg;
   logic              ack_reg;
   logic [31:0]       dat_reg;

   // ==========================================
   // Bus decode
   logic                 access;
   logic                 wr;
   logic                 rd;
   logic                 lane0;
   logic [TPC_ADR_W-1:0] idx;
   logic                 hit_sc;
   logic                 hit_cnt;
   logic                 hit_mod;

   // Single-cycle answer; ack drops for one cycle between requests
   assign access  = wb_cyc_i && wb_stb_i && !ack_reg;
   assign wr      = access && wb_we_i;
   assign rd      = access && !wb_we_i;
   assign lane0   = wb_sel_i[0];
   assign idx     = wb_adr_i[TPC_ADR_LSB +: TPC_ADR_W];
   assign hit_sc  = (idx == TPC_IDX_SC);
   assign hit_cnt = (idx == TPC_IDX_CNTH) || (idx == TPC_IDX_CNTL);
   assign hit_mod = (idx == TPC_IDX_MODH) || (idx == TPC_IDX_MODL);

   logic wr_sc;
   logic wr_cnt;
   logic rd_cnt;
   logic rd_sc;
   assign wr_sc  = wr && lane0 && hit_sc;
   assign wr_cnt = wr && lane0 && hit_cnt;
   assign rd_cnt = rd && hit_cnt;
   assign rd_sc  = rd && hit_sc;

   // ==========================================
   // Clock source synchronizers
   // synchronize slow sources
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         fix_sync_reg <= 3'h0;
         ext_sync_reg <= 3'h0;
      end else begin
         fix_sync_reg <= {fix_sync_reg[1:0], fixed_system_clock_i};
         ext_sync_reg <= {ext_sync_reg[1:0], external_timer_clock_in_i};
      end
   end

   logic fix_rise;
   logic ext_rise;
   assign fix_rise = fix_sync_reg[1] && !fix_sync_reg[2];
   assign ext_rise = ext_sync_reg[1] && !ext_sync_reg[2];

   logic src_tick;
   always_comb begin
      case (ctrl_reg.clk_src)
         TPC_CLK_BUS: src_tick = 1'b1;
         TPC_CLK_FIX: src_tick = fix_rise;
         TPC_CLK_EXT: src_tick = ext_rise;
         default:     src_tick = 1'b0;
      endcase
   end

   // ==========================================
   // Prescaler after selection
   logic [PS_W-1:0] ps_mask;
   logic            tick;
   assign ps_mask = PS_W'((TPC_PS_ONE << ctrl_reg.prescale) - TPC_PS_ONE);
   // divide by two to the field value
   assign tick = src_tick && !debug_mode_i && ((ps_count_reg & ps_mask) == ps_mask);

   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         ps_count_reg <= '0;
      end else if (ctrl_reg.clk_src == TPC_CLK_NONE) begin
         ps_count_reg <= '0;
      end else if (src_tick && !debug_mode_i) begin
         ps_count_reg <= (tick) ? '0 : ps_count_reg + 1'b1;
      end
   end

   // ==========================================
   // Counter
   logic free_run;
   logic at_mod;
   logic up_wrap;
   logic ctr_turn;
   logic ovf_event;
   assign free_run = (modulo_reg == TPC_MOD_RST) || (modulo_reg == TPC_MOD_ONES);
   assign at_mod   = free_run ? (count_reg == TPC_MOD_ONES) : (count_reg == modulo_reg);
   assign up_wrap  = tick && !ctrl_reg.center && at_mod;
   assign ctr_turn = tick && ctrl_reg.center && !count_down_reg && at_mod;
   // flag at turn toward lower count
   // suppressed while a modulo byte pair is open
   assign ovf_event = (up_wrap || ctr_turn) && !mod_pend_reg;

   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         count_reg      <= TPC_CNT_RST;
         count_down_reg <= 1'b0;
      end else if (wr_cnt) begin
         count_reg      <= TPC_CNT_RST;
         count_down_reg <= 1'b0;
      end else if (tick) begin
         if (!ctrl_reg.center) begin
            count_down_reg <= 1'b0;
            count_reg      <= at_mod ? TPC_CNT_RST : count_reg + TPC_CNT_ONE;
         end else if (!count_down_reg) begin
            count_down_reg <= at_mod;
            count_reg      <= at_mod ? count_reg - TPC_CNT_ONE : count_reg + TPC_CNT_ONE;
         end else begin
            // triangle: down to zero then up again
            count_down_reg <= (count_reg != TPC_CNT_ONE);
            count_reg      <= count_reg - TPC_CNT_ONE;
         end
      end
   end

   // ==========================================
   // Status/control and overflow flag
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         ctrl_reg <= '0;
      end else if (wr_sc) begin
         ctrl_reg <= tpc_ctrl_t'(wb_dat_i[TPC_SC_OIE:TPC_SC_PSL]);
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         overflow_flag_reg <= 1'b0;
         clr_armed_reg     <= 1'b0;
      end else if (ovf_event) begin
         // new overflow wins and cancels the clear sequence
         overflow_flag_reg <= 1'b1;
         clr_armed_reg     <= 1'b0;
      end else if (wr_sc) begin
         // clear needs a prior read while set
         // writing one leaves the flag alone
         if (clr_armed_reg && !wb_dat_i[TPC_SC_OVF]) begin
            overflow_flag_reg <= 1'b0;
         end
         clr_armed_reg <= 1'b0;
      end else if (rd_sc && overflow_flag_reg) begin
         clr_armed_reg <= 1'b1;
      end
   end

   // ==========================================
   // Modulo byte pairing
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         modulo_reg   <= TPC_MOD_RST;
         mod_hold_reg <= 8'h00;
         mod_pend_reg <= 1'b0;
      end else if (wr && lane0 && hit_mod) begin
         // first byte held, pair completes on second
         if (!mod_pend_reg) begin
            mod_hold_reg <= wb_dat_i[7:0];
            mod_pend_reg <= 1'b1;
         end else begin
            mod_pend_reg <= 1'b0;
            if (idx == TPC_IDX_MODH) begin
               modulo_reg <= {wb_dat_i[7:0], mod_hold_reg};
            end else begin
               modulo_reg <= {mod_hold_reg, wb_dat_i[7:0]};
            end
         end
      end
   end

   // ==========================================
   // Counter read coherency
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         latched_reg   <= 1'b0;
         latch_val_reg <= TPC_CNT_RST;
      end else if (wr_cnt || wr_sc) begin
         latched_reg <= 1'b0;
      end else if (rd_cnt && !debug_mode_i) begin
         // first read freezes both bytes, second releases
         // debug mode holds the latch state
         latched_reg <= !latched_reg;
         if (!latched_reg) begin
            latch_val_reg <= count_reg;
         end
      end
   end

   logic [15:0] cnt_view;
   assign cnt_view = latched_reg ? latch_val_reg : count_reg;

   // ==========================================
   // Read data and ack
   logic [7:0] rd_byte;
   always_comb begin
      case (idx)
         TPC_IDX_SC:   rd_byte = {overflow_flag_reg, ctrl_reg};
         TPC_IDX_CNTH: rd_byte = cnt_view[15:8];
         TPC_IDX_CNTL: rd_byte = cnt_view[7:0];
         TPC_IDX_MODH: rd_byte = modulo_reg[15:8];
         TPC_IDX_MODL: rd_byte = modulo_reg[7:0];
         default:      rd_byte = 8'h00;
      endcase
   end

   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         ack_reg <= 1'b0;
         dat_reg <= 32'h0000_0000;
      end else begin
         ack_reg <= access;
         if (rd) begin
            dat_reg <= {24'h00_0000, rd_byte};
         end
      end
   end

   assign wb_ack_o                = ack_reg;
   assign wb_dat_o                = dat_reg;
   assign count_o                 = count_reg;
   assign center_aligned_select_o = ctrl_reg.center;
   // request while flag and enable are set
   assign overflow_irq_o          = overflow_flag_reg && ctrl_reg.irq_en;

   // ==========================================
   // Assertions
   a_wrap_sets_flag: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      (up_wrap && !mod_pend_reg && !wr_cnt) |=> (overflow_flag_reg && count_reg == TPC_CNT_RST))
      else $error("wrap did not set flag");
   a_turn_sets_flag: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      (ctr_turn && !mod_pend_reg && !wr_cnt) |=> (overflow_flag_reg && count_down_reg))
      else $error("center turn did not set flag");
   a_clear_needs_read: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      ($fell(overflow_flag_reg)) |-> ($past(clr_armed_reg) && $past(wr_sc)))
      else $error("flag cleared without sequence");
   a_event_beats_clear: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      ovf_event |=> overflow_flag_reg)
      else $error("overflow lost");
   a_irq_follows_flag: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      overflow_irq_o == (overflow_flag_reg && ctrl_reg.irq_en))
      else $error("irq mismatch");
   a_no_clock_hold: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      (ctrl_reg.clk_src == TPC_CLK_NONE && !wr_cnt && $past(ctrl_reg.clk_src) == TPC_CLK_NONE)
      |=> $stable(count_reg))
      else $error("counter moved with no clock");
   a_cnt_write_clear: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      wr_cnt |=> (count_reg == TPC_CNT_RST))
      else $error("counter write did not clear");
   a_debug_freeze: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      (debug_mode_i && !wr_cnt && !wr_sc) |=> ($stable(count_reg) && $stable(latched_reg)))
      else $error("debug did not freeze");
   a_mod_pend_block: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      (mod_pend_reg && !ovf_event && !wr_sc && !overflow_flag_reg) |=> !overflow_flag_reg)
      else $error("flag set during modulo pair");

endmodule
`default_nettype wire

// ---- tpc_counter_base_tb.sv ----
// Self-checking testbench for the timer/PWM counter base
`default_nettype none
module tpc_counter_base_tb
   import tpc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   // ==========================================
   // Stimulus and observed signals
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        cyc = 1'b0;
   logic        stb = 1'b0;
   logic        we = 1'b0;
   logic [31:0] adr = 32'h0;
   logic [31:0] wdat = 32'h0;
   logic [3:0]  sel = 4'h1;
   logic [31:0] rdat;
   logic        ack;
   logic        fclk = 1'b0;
   logic        fixed_system_clock = 1'b0;
   logic        dbg = 1'b0;
   logic [15:0] cnt;
   logic        cas;
   logic        irq;
   logic [2:0]  div = 3'h0;
   logic [15:0] c0;
   logic [7:0]  rv;
   int          mismatches = 0;
   int          total_checks = 0;

   always #2 clk = ~clk;

   // Both slow sources toggle every 4 bus cycles, well under the allowed rate
   always @(posedge clk) begin
      div  <= div + 3'h1;
      fclk <= div[2];
      fixed_system_clock <= div[2];
   end

   tpc_counter_base u_tpc_counter_base (
      .sys_clk_i                 (clk),
      .reset_n_i                 (rst_n),
      .wb_cyc_i                  (cyc),
      .wb_stb_i                  (stb),
      .wb_we_i                   (we),
      .wb_adr_i                  (adr),
      .wb_dat_i                  (wdat),
      .wb_sel_i                  (sel),
      .wb_dat_o                  (rdat),
      .wb_ack_o                  (ack),
      .fixed_system_clock_i      (fclk),
      .external_timer_clock_in_i (fixed_system_clock),
      .debug_mode_i              (dbg),
      .count_o                   (cnt),
      .center_aligned_select_o   (cas),
      .overflow_irq_o            (irq)
   );

   // ==========================================
   // Shared tasks
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic hang(input string what);
      mismatches++;
      $display("CHECK FAILED %s expected done seen timeout", what);
      give_verdict();
   endtask

   // Classic cycle: held until ack is sampled high, then released for a cycle
   task automatic bus(input logic w, input logic [3:0] i, input logic [7:0] d, output logic [7:0] r);
      int n;
      n = 0;
      @(posedge clk);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= {26'h0, i, 2'h0};
      wdat <= {24'h0, d};
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      if (ack !== 1'b1) hang("bus ack");
      r = rdat[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
   endtask

   task automatic wr(input logic [3:0] i, input logic [7:0] d);
      logic [7:0] x;
      bus(1'b1, i, d, x);
   endtask

   task automatic rdc(input string what, input logic [3:0] i, input logic [7:0] e);
      bus(1'b0, i, 8'h00, rv);
      chk(what, {8'h00, e}, {8'h00, rv});
   endtask

   task automatic wait_cnt(input logic [15:0] v);
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (cnt !== v && n < 2000);
      if (cnt !== v) hang("count value");
   endtask

   // Counter advance over 256 cycles once the selected source is settled
   task automatic rate(input logic [7:0] sc, input logic [15:0] e);
      wr(TPC_IDX_SC, sc);
      repeat (16) @(posedge clk);
      c0 = cnt;
      repeat (256) @(posedge clk);
      chk("count advance", e, cnt - c0);
   endtask

   // ==========================================
   // Scenarios
   task automatic t_reset;
      chk("irq after reset", 16'h0, 16'(irq));             // flag cleared
      rdc("sc reset", TPC_IDX_SC, 8'h00);                  // reset clears
      rdc("cnth reset", TPC_IDX_CNTH, 8'h00);              // counter zero
      rdc("cntl reset", TPC_IDX_CNTL, 8'h00);              // counter zero
      rdc("modh reset", TPC_IDX_MODH, 8'h00);              // modulo zero
      rdc("modl reset", TPC_IDX_MODL, 8'h00);              // modulo zero
      wr(4'h5, 8'hff);
      rdc("unmapped", 4'h5, 8'h00);
      wr(TPC_IDX_SC, 8'h65);
      rdc("sc fields", TPC_IDX_SC, 8'h65);                 // readback
      chk("center out", 16'h1, 16'(cas));                  // center select
      wr(TPC_IDX_MODH, 8'h12);
      wr(TPC_IDX_MODL, 8'h34);
      rdc("modh rw", TPC_IDX_MODH, 8'h12);
      rdc("modl rw", TPC_IDX_MODL, 8'h34);
   endtask

   task automatic t_rates;
      wr(TPC_IDX_MODH, 8'hff);
      wr(TPC_IDX_MODL, 8'hff);
      for (int p = 0; p < 8; p++) begin
         rate({5'b00001, 3'(p)}, 16'(256 >> p));          // divide and free run
      end
      rate(8'h00, 16'h0);                                  // no clock
      rate(8'h10, 16'h0020);                               // fixed clock
      rate(8'h19, 16'h0010);                               // external halved
   endtask

   task automatic t_debug;
      wr(TPC_IDX_SC, 8'h08);
      dbg <= 1'b1;
      rate(8'h08, 16'h0);                                  // counter frozen
      dbg <= 1'b0;
      rate(8'h08, 16'h0100);                               // resumes
   endtask

   task automatic t_latch;
      wr(TPC_IDX_CNTL, 8'h5a);
      chk("cleared", 16'h1, 16'(cnt < 16'h0008));         // write clears
      repeat (200) @(posedge clk);
      bus(1'b0, TPC_IDX_CNTL, 8'h00, rv);
      repeat (100) @(posedge clk);
      rdc("held high", TPC_IDX_CNTH, 8'h00);               // coherent pair
      rdc("fresh high", TPC_IDX_CNTH, 8'h01);              // released
      bus(1'b0, TPC_IDX_CNTL, 8'h00, rv);
      bus(1'b0, TPC_IDX_CNTL, 8'h00, rv);
      wr(TPC_IDX_SC, 8'h08);
      repeat (200) @(posedge clk);
      rdc("rearmed high", TPC_IDX_CNTH, 8'h02);            // latch set by the last low-byte read, released by the control write; live value read
      bus(1'b0, TPC_IDX_CNTL, 8'h00, rv);
   endtask

   task automatic t_up;
      wr(TPC_IDX_SC, 8'h00);
      wr(TPC_IDX_CNTH, 8'h00);
      wr(TPC_IDX_MODH, 8'h00);
      wr(TPC_IDX_MODL, 8'h20);
      wr(TPC_IDX_SC, 8'h48);
      wait_cnt(16'h0020);
      wait_cnt(16'h0002);
      rdc("flag set", TPC_IDX_SC, 8'hc8);                  // overflow seen
      wr(TPC_IDX_SC, 8'h48);
      chk("irq cleared", 16'h0, 16'(irq));                 // read then zero
      wr(TPC_IDX_SC, 8'hc8);
      rdc("one ignored", TPC_IDX_SC, 8'h48);               // one has no effect
      wait_cnt(16'h0020);
      chk("irq before wrap", 16'h0, 16'(irq));             // not early
      @(posedge clk);
      chk("wrap count", 16'h0, cnt);                       // restart at zero
      chk("irq at wrap", 16'h1, 16'(irq));                 // flag and request
      wr(TPC_IDX_SC, 8'h48);
      rdc("no arm", TPC_IDX_SC, 8'hc8);                    // needs prior read
      bus(1'b0, TPC_IDX_SC, 8'h00, rv);
      wait_cnt(16'h0020);
      @(posedge clk);
      wr(TPC_IDX_SC, 8'h48);
      rdc("clear lost", TPC_IDX_SC, 8'hc8);                // new overflow kept
      bus(1'b0, TPC_IDX_SC, 8'h00, rv);
      wr(TPC_IDX_SC, 8'h48);
      wr(TPC_IDX_MODH, 8'h00);
      repeat (100) @(posedge clk);
      chk("pending modulo", 16'h0, 16'(irq));              // flag blocked
      wr(TPC_IDX_MODL, 8'h20);
      wait_cnt(16'h0020);
      @(posedge clk);
      chk("pair done", 16'h1, 16'(irq));                   // setting resumes
   endtask

   task automatic t_center;
      wr(TPC_IDX_SC, 8'h68);
      chk("center out", 16'h1, 16'(cas));                  // center select
      wait_cnt(16'h0020);
      bus(1'b0, TPC_IDX_SC, 8'h00, rv);
      wr(TPC_IDX_SC, 8'h68);
      chk("irq cleared", 16'h0, 16'(irq));                 // read then zero
      wait_cnt(16'h0000);
      @(posedge clk);
      chk("bottom turn", 16'h1, cnt);                      // up again
      chk("no flag low", 16'h0, 16'(irq));                 // not at bottom
      wait_cnt(16'h0020);
      @(posedge clk);
      chk("top turn", 16'h001f, cnt);                      // counts down
      chk("flag top", 16'h1, 16'(irq));                    // set on step down
   endtask

   // Reset in mid-run with the flag set and a modulo programmed
   task automatic t_rst2;
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      chk("irq mid reset", 16'h0, 16'(irq));               // reset clears flag
      chk("count mid reset", 16'h0, cnt);                  // counter zero
      rdc("sc mid reset", TPC_IDX_SC, 8'h00);              // reset clears
      rdc("modl mid reset", TPC_IDX_MODL, 8'h00);          // modulo zero
   endtask

   // ==========================================
   // Main sequence
   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_rates();
      t_debug();
      t_latch();
      t_up();
      t_center();
      t_rst2();
      give_verdict();
   end
endmodule
`default_nettype wire
